// ===== pus_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pus_chk #(
    parameter int unsigned GPIO_W = 4,
    parameter int unsigned READY_CYCLES = 200,
    parameter int unsigned HOLD_CYCLES = 200
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic supply_good,
    input wire logic video_clk_stable,
    input wire logic power_enable_pin,
    input wire logic video_src_enable,
    input wire logic [GPIO_W-1:0] gpio_out,
    input wire logic gpio_oe,
    input wire logic scl_oe,
    input wire logic sda_oe
);
    import pus_pkg::*;
    logic [16:0] hi_reg, lo_reg, stab_reg;
    logic [3:0] frm_reg;
    logic sda_q_reg;
    // counters saturate so a long run cannot wrap into a false pass
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hi_reg <= '0;
            lo_reg <= '0;
            stab_reg <= '0;
            frm_reg <= '0;
            sda_q_reg <= 1'h0;
        end else begin
            hi_reg <= power_enable_pin ? hi_reg + 17'(~&hi_reg) : '0;
            lo_reg <= power_enable_pin ? '0 : lo_reg + 17'(~&lo_reg);
            stab_reg <= video_clk_stable ? stab_reg + 17'(~&stab_reg) : '0;
            frm_reg <= power_enable_pin ? frm_reg + 4'(sda_oe && !sda_q_reg
                && !scl_oe && ~&frm_reg) : '0;
            sda_q_reg <= sda_oe;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    bus_after_ready_a: assert property ((scl_oe || sda_oe) |->
        power_enable_pin && hi_reg >= READY_CYCLES - 1)
        else $error("control bus used too early");
    hold_low_min_a: assert property ($rose(power_enable_pin) |->
        $past(lo_reg) >= HOLD_CYCLES - 1) else $error("low pulse too short");
    enable_after_supply_a: assert property ($rose(power_enable_pin) |->
        $past(supply_good)) else $error("enable before supply");
    supply_loss_a: assert property (!supply_good |->
        ##[1:2] !power_enable_pin) else $error("enable kept without supply");
    drive_after_supply_a: assert property (gpio_oe |->
        $past(supply_good)) else $error("gpio driven without supply");
    gpio_frozen_a: assert property (!power_enable_pin &&
        !$past(power_enable_pin) |-> $stable(gpio_out))
        else $error("gpio changed while disabled");
    video_after_init_a: assert property ($rose(video_src_enable) |->
        power_enable_pin && frm_reg == 4'h2) else $error("video too early");
    clock_settle_a: assert property (sda_oe && !$past(sda_oe) &&
        !scl_oe && frm_reg >= 4'h2 |-> stab_reg >= CLOCK_STABLE_CYCLES - 1)
        else $error("pll reset before clock settled");
endmodule // pus_chk
`default_nettype wire

// ===== pus_delay_timer.sv
`timescale 1ns/1ps
`default_nettype none
module pus_delay_timer #(
    parameter int unsigned W = pus_pkg::TIMER_W
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [W-1:0] load,
    output logic expired
);
    import pus_pkg::*;
    typedef struct packed {
        logic [W-1:0] cnt;
    } pus_tmr_t;
    pus_tmr_t s_reg, s_next;

    always_comb begin
        s_next = s_reg;
        if (start) begin
            s_next.cnt = load;
        end else if (s_reg.cnt != '0) begin
            s_next.cnt = s_reg.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // a reload in this cycle hides a stale zero
    assign expired = (s_reg.cnt == '0) && !start;
endmodule // pus_delay_timer
`default_nettype wire

// ===== pus_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module pus_dev_model #(
    parameter logic [6:0] ADDR = 7'h2a,
    parameter int READY = 200
) (
    input wire logic clk_sys,
    input wire logic en,
    input wire logic scl,
    input wire logic sda,
    output logic sda_pull
);
    logic [7:0] regs [256];
    logic [15:0] log_q [$];
    logic [1:0] pll_hold;
    logic [7:0] sh, ptr;
    logic ps, pd, act;
    int cnt, nb, nby;
    wire logic auto_rst = regs[8'h5b][5];
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        regs[a] = d;
        log_q.push_back({a, d});
        if (a == 8'h42 && regs[8'h41] == 8'h49 && regs[8'h40][7:3] == 5'h2)
            pll_hold[regs[8'h40][2]] = d[4];
    endtask
    // sampled on the system clock; the frame is far slower, so no edge is lost
    always @(posedge clk_sys) begin
        if (!en) begin
            cnt = 0;
            act = 1'h0;
            sda_pull <= 1'h0;
            pll_hold = 2'h3;
            foreach (regs[i]) regs[i] = 8'hff; // arbitrary power-on content
        end else begin
            if (cnt < READY) cnt++;
            if (scl && ps && pd && !sda) begin
                act = 1'h1;
                nb = 0;
                nby = 0;
            end else if (scl && ps && !pd && sda) begin
                act = 1'h0;
            end else if (act && scl && !ps && nb < 8) begin
                sh = {sh[6:0], sda};
                nb++;
            end else if (act && !scl && ps && nb == 9) begin
                sda_pull <= 1'h0;
                nb = 0;
                nby++;
            end else if (act && !scl && ps && nb == 8) begin
                act = cnt >= READY && (nby > 0 || sh == {ADDR, 1'h0});
                sda_pull <= act;
                nb = 9;
                if (act && nby == 1) ptr = sh;
                if (act && nby == 2) put(ptr, sh);
            end
        end
        ps = scl;
        pd = sda;
    end
endmodule // pus_dev_model
`default_nettype wire

// ===== pus_i2c_writer.sv
`timescale 1ns/1ps
`default_nettype none
module pus_i2c_writer #(
    parameter logic [6:0] DEV_ADDR = 7'h2a,
    parameter logic [pus_pkg::QDIV_W-1:0] QUARTER =
        pus_pkg::QDIV_W'(pus_pkg::I2C_QUARTER_CYCLES)
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    pus_wr_if.drv wr,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);
    import pus_pkg::*;
    // DEV_ADDR default is arbitrary; set it to the board's strap
    typedef struct packed {
        pus_wstate_t st;
        logic [QDIV_W-1:0] div;
        logic [1:0] q;
        logic [1:0] nbyte;
        logic [3:0] nbit;
        logic [7:0] sh;
        logic [7:0] reg_b;
        logic [7:0] dat_b;
        logic scl_low;
        logic sda_low;
        logic nack;
    } pus_wr_state_t;
    pus_wr_state_t s_reg, s_next;
    logic tick;

    always_comb begin
        s_next = s_reg;
        tick = (s_reg.div == QUARTER - 1'b1);
        s_next.div = tick ? '0 : s_reg.div + 1'b1;
        // clock stretching: a slave holding scl low freezes the bit
        if (!s_reg.scl_low && !scl_i) begin
            s_next.div = s_reg.div;
            tick = 1'b0;
        end
        if (tick) begin
            s_next.q = s_reg.q + 1'b1;
        end
        unique case (s_reg.st)
            PUS_W_IDLE: begin
                s_next.div = '0;
                s_next.q = '0;
                if (wr.req) begin
                    s_next.st = PUS_W_START;
                    s_next.sh = {DEV_ADDR, 1'b0};
                    s_next.reg_b = wr.reg_addr;
                    s_next.dat_b = wr.data;
                    s_next.nbyte = '0;
                    s_next.nbit = '0;
                    s_next.nack = 1'b0;
                end
            end
            PUS_W_START: begin
                if (tick && s_reg.q == 2'd0) begin
                    s_next.sda_low = 1'b1;
                end
                if (tick && s_reg.q == 2'd1) begin
                    s_next.scl_low = 1'b1;
                    s_next.q = '0;
                    s_next.st = PUS_W_BIT;
                end
            end
            PUS_W_BIT: begin
                if (tick) begin
                    unique case (s_reg.q)
                        2'd0: s_next.sda_low =
                            (s_reg.nbit == 4'd8) ? 1'b0 : !s_reg.sh[7];
                        2'd1: s_next.scl_low = 1'b0;
                        2'd2: begin
                            if (s_reg.nbit == 4'd8 && sda_i) begin
                                s_next.nack = 1'b1;
                            end
                        end
                        2'd3: begin
                            s_next.scl_low = 1'b1;
                            if (s_reg.nbit != 4'd8) begin
                                s_next.sh = {s_reg.sh[6:0], 1'b0};
                                s_next.nbit = s_reg.nbit + 1'b1;
                            end else if (s_reg.nack || s_reg.nbyte == 2'd2) begin
                                s_next.st = PUS_W_STOP;
                            end else begin
                                s_next.nbyte = s_reg.nbyte + 1'b1;
                                s_next.nbit = '0;
                                s_next.sh = (s_reg.nbyte == 2'd0) ?
                                    s_reg.reg_b : s_reg.dat_b;
                            end
                        end
                    endcase
                end
            end
            PUS_W_STOP: begin
                if (tick) begin
                    unique case (s_reg.q)
                        2'd0: s_next.sda_low = 1'b1;
                        2'd1: s_next.scl_low = 1'b0;
                        2'd2: s_next.sda_low = 1'b0;
                        2'd3: s_next.st = PUS_W_DONE;
                    endcase
                end
            end
            PUS_W_DONE: s_next.st = PUS_W_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '{st: PUS_W_IDLE, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    // open drain: drive only low, release for high
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe = s_reg.scl_low;
    assign sda_oe = s_reg.sda_low;
    assign wr.ready = (s_reg.st == PUS_W_IDLE);
    assign wr.done = (s_reg.st == PUS_W_DONE);
    assign wr.nack = s_reg.nack;
endmodule // pus_i2c_writer
`default_nettype wire

// ===== pus_pkg.sv
package pus_pkg;
    // system clock and timing figures
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned CONTROL_READY_DELAY_MS = 2;
    localparam int unsigned HARD_RESET_PULSE_MIN_MS = 2;
    localparam int unsigned CLOCK_STABLE_TO_PLL_RESET_US = 1;
    localparam int unsigned SUPPLY_TO_ENABLE_DELAY_MS = 0;
    localparam int unsigned I2C_BIT_HZ = 100_000;
    // least times round up to whole cycles
    localparam int unsigned CONTROL_READY_CYCLES =
        (CONTROL_READY_DELAY_MS * (CLK_HZ / 1000) + 0);
    localparam int unsigned HARD_RESET_CYCLES =
        (HARD_RESET_PULSE_MIN_MS * (CLK_HZ / 1000) + 0);
    localparam int unsigned CLOCK_STABLE_CYCLES =
        (CLOCK_STABLE_TO_PLL_RESET_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int unsigned I2C_QUARTER_CYCLES = CLK_HZ / (4 * I2C_BIT_HZ);
    localparam int unsigned TIMER_W = 17;
    localparam int unsigned QDIV_W = 8;

    // device registers, reached over the serial control port
    localparam logic [7:0] DEV_LINK_PLL_AUTO_RESET_CONTROL = 8'h5b;
    localparam int unsigned LINK_PLL_AUTO_RESET_BIT = 5;
    localparam logic [7:0] DEV_CONTROL_BUS_EVENT_FILTER = 8'h16;
    localparam logic [7:0] EVENT_FILTER_VALUE = 8'h02;
    localparam logic [7:0] DEV_PAGE_SELECT = 8'h40;
    localparam logic [7:0] DEV_PAGE_INDEX = 8'h41;
    localparam logic [7:0] DEV_PAGE_DATA_WINDOW = 8'h42;
    localparam logic [7:0] PAGE_VIDEO_PLL = 8'h10;
    localparam logic [7:0] PAGE_SERIAL_LINK_PLL = 8'h14;
    localparam logic [7:0] PLL_CONTROL_INDEX = 8'h49;
    localparam logic [7:0] PLL_RESET_HOLD = 8'h10;
    localparam logic [7:0] PLL_RESET_RELEASE = 8'h00;
    localparam logic [3:0] LAST_STEP_A = 4'h1;
    localparam logic [3:0] LAST_STEP_B = 4'h9;

    // controller's own registers, byte addresses
    localparam logic [3:0] CSR_CTRL = 4'h0;
    localparam logic [3:0] CSR_STATUS = 4'h4;
    localparam logic [3:0] CSR_AUTO_RESET_CFG = 4'h8;
    localparam logic [3:0] CSR_GPIO = 4'hc;
    localparam int unsigned CTRL_POWER_UP = 0;
    localparam int unsigned CTRL_HARD_RESET = 1;
    localparam int unsigned CTRL_POWER_OFF = 2;
    localparam logic [7:0] AUTO_RESET_CFG_RESET = 8'h00;

    typedef enum logic [8:0] {
        PUS_OFF = 9'b000000001,
        PUS_HOLD_LOW = 9'b000000010,
        PUS_WAIT_SUPPLY = 9'b000000100,
        PUS_READY_WAIT = 9'b000001000,
        PUS_INIT_A = 9'b000010000,
        PUS_CLK_WAIT = 9'b000100000,
        PUS_INIT_B = 9'b001000000,
        PUS_RUNNING = 9'b010000000,
        PUS_FAULT = 9'b100000000
    } pus_state_t;

    typedef enum logic [4:0] {
        PUS_W_IDLE = 5'b00001,
        PUS_W_START = 5'b00010,
        PUS_W_BIT = 5'b00100,
        PUS_W_STOP = 5'b01000,
        PUS_W_DONE = 5'b10000
    } pus_wstate_t;
endpackage

// ===== pus_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module pus_sequencer #(
    parameter int unsigned GPIO_W = 4,
    parameter int unsigned READY_CYCLES = pus_pkg::CONTROL_READY_CYCLES,
    parameter int unsigned HOLD_CYCLES = pus_pkg::HARD_RESET_CYCLES,
    parameter logic [6:0] DEV_ADDR = 7'h2a,
    parameter logic [pus_pkg::QDIV_W-1:0] I2C_QUARTER =
        pus_pkg::QDIV_W'(pus_pkg::I2C_QUARTER_CYCLES)
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic supply_good,
    input wire logic video_clk_stable,
    output logic power_enable_pin,
    output logic video_src_enable,
    output logic [GPIO_W-1:0] gpio_out,
    output logic gpio_oe,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);
    import pus_pkg::*;
    // DEV_ADDR default is arbitrary

    typedef struct packed {
        pus_state_t st;
        logic [3:0] step;
        logic pending;
        logic nack_seen;
        logic enable;
        logic video_on;
        logic drive_ok;
        logic [7:0] auto_cfg;
        logic [GPIO_W-1:0] gpio_sw;
        logic [GPIO_W-1:0] gpio_pin;
        logic ack;
        logic [31:0] rdata;
    } pus_seq_state_t;
    pus_seq_state_t s_reg, s_next;

    pus_wr_if wr ();
    logic tmr_start;
    logic [TIMER_W-1:0] tmr_load;
    logic tmr_expired;
    logic bus_cyc;
    logic wr_take;
    logic cmd_up;
    logic cmd_reset;
    logic cmd_off;

    // one device write per step: {register, data}
    function automatic logic [15:0] step_write(input logic [3:0] step,
                                               input logic [7:0] cfg);
        logic [7:0] cfg_clr;
        cfg_clr = cfg;
        cfg_clr[LINK_PLL_AUTO_RESET_BIT] = 1'b0;
        unique case (step)
            4'd0: step_write = {DEV_LINK_PLL_AUTO_RESET_CONTROL, cfg_clr};
            4'd1: step_write = {DEV_CONTROL_BUS_EVENT_FILTER,
                                EVENT_FILTER_VALUE};
            4'd2: step_write = {DEV_PAGE_SELECT, PAGE_VIDEO_PLL};
            4'd3: step_write = {DEV_PAGE_INDEX, PLL_CONTROL_INDEX};
            4'd4: step_write = {DEV_PAGE_DATA_WINDOW, PLL_RESET_HOLD};
            4'd5: step_write = {DEV_PAGE_DATA_WINDOW, PLL_RESET_RELEASE};
            4'd6: step_write = {DEV_PAGE_SELECT, PAGE_SERIAL_LINK_PLL};
            4'd7: step_write = {DEV_PAGE_INDEX, PLL_CONTROL_INDEX};
            4'd8: step_write = {DEV_PAGE_DATA_WINDOW, PLL_RESET_HOLD};
            4'd9: step_write = {DEV_PAGE_DATA_WINDOW, PLL_RESET_RELEASE};
            default: step_write = {DEV_PAGE_DATA_WINDOW, PLL_RESET_RELEASE};
        endcase
    endfunction

    assign bus_cyc = (avs_read || avs_write) && !s_reg.ack;
    assign avs_waitrequest = bus_cyc;
    assign cmd_up = avs_write && s_reg.ack && avs_address == CSR_CTRL &&
                    avs_writedata[CTRL_POWER_UP];
    assign cmd_reset = avs_write && s_reg.ack && avs_address == CSR_CTRL &&
                       avs_writedata[CTRL_HARD_RESET];
    assign cmd_off = avs_write && s_reg.ack && avs_address == CSR_CTRL &&
                     avs_writedata[CTRL_POWER_OFF];

    // writes are issued only from the two init states
    assign wr.req = (s_reg.st == PUS_INIT_A || s_reg.st == PUS_INIT_B) &&
                    !s_reg.pending;
    assign {wr.reg_addr, wr.data} = step_write(s_reg.step, s_reg.auto_cfg);
    assign wr_take = wr.req && wr.ready;

    always_comb begin
        s_next = s_reg;
        tmr_start = 1'b0;
        tmr_load = '0;
        // bus slave: one wait cycle, then the access completes
        s_next.ack = bus_cyc;
        if (bus_cyc && avs_read) begin
            unique case (avs_address)
                CSR_STATUS: s_next.rdata = {12'h000, video_clk_stable,
                                            supply_good, s_reg.enable,
                                            s_reg.nack_seen, 7'h00,
                                            s_reg.st};
                CSR_AUTO_RESET_CFG: s_next.rdata = {24'h000000,
                                                    s_reg.auto_cfg};
                CSR_GPIO: s_next.rdata = 32'(s_reg.gpio_sw);
                default: s_next.rdata = 32'h00000000;
            endcase
        end
        if (avs_write && s_reg.ack) begin
            if (avs_address == CSR_AUTO_RESET_CFG) begin
                s_next.auto_cfg = avs_writedata[7:0];
            end
            if (avs_address == CSR_GPIO) begin
                s_next.gpio_sw = avs_writedata[GPIO_W-1:0];
            end
        end
        if (wr_take) begin
            s_next.pending = 1'b1;
        end
        // gpio pins freeze until enable is high, then follow software
        if (s_reg.enable) begin
            s_next.gpio_pin = s_reg.gpio_sw;
        end
        s_next.drive_ok = supply_good;

        unique case (s_reg.st)
            PUS_OFF: begin
                if (cmd_up) begin
                    s_next.st = PUS_HOLD_LOW;
                    tmr_start = 1'b1;
                    tmr_load = TIMER_W'(HOLD_CYCLES);
                end
            end
            PUS_HOLD_LOW: begin
                if (tmr_expired) begin
                    s_next.st = PUS_WAIT_SUPPLY;
                end
            end
            PUS_WAIT_SUPPLY: begin
                if (supply_good) begin
                    s_next.st = PUS_READY_WAIT;
                    s_next.enable = 1'b1;
                    tmr_start = 1'b1;
                    tmr_load = TIMER_W'(READY_CYCLES);
                end
            end
            PUS_READY_WAIT: begin
                if (tmr_expired) begin
                    s_next.st = PUS_INIT_A;
                    s_next.step = 4'd0;
                end
            end
            PUS_INIT_A, PUS_INIT_B: begin
                if (wr.done) begin
                    s_next.pending = 1'b0;
                    if (wr.nack) begin
                        s_next.st = PUS_FAULT;
                        s_next.nack_seen = 1'b1;
                    end else if (s_reg.step == LAST_STEP_A &&
                                 s_reg.st == PUS_INIT_A) begin
                        s_next.st = PUS_CLK_WAIT;
                        s_next.video_on = 1'b1;
                        s_next.step = s_reg.step + 1'b1;
                    end else if (s_reg.step == LAST_STEP_B) begin
                        s_next.st = PUS_RUNNING;
                    end else begin
                        s_next.step = s_reg.step + 1'b1;
                    end
                end
            end
            PUS_CLK_WAIT: begin
                // any unstable cycle restarts the settle count
                if (!video_clk_stable) begin
                    tmr_start = 1'b1;
                    tmr_load = TIMER_W'(CLOCK_STABLE_CYCLES);
                end else if (tmr_expired) begin
                    s_next.st = PUS_INIT_B;
                end
            end
            PUS_RUNNING, PUS_FAULT: begin
            end
            default: s_next.st = PUS_FAULT;
        endcase

        // a restart, or supply loss while enable is high, overrides any stage
        if (cmd_reset || (!supply_good && s_reg.enable)) begin
            s_next.st = PUS_HOLD_LOW;
            s_next.enable = 1'b0;
            s_next.video_on = 1'b0;
            s_next.pending = 1'b0;
            s_next.nack_seen = 1'b0;
            tmr_start = 1'b1;
            tmr_load = TIMER_W'(HOLD_CYCLES);
        end else if (cmd_off) begin
            s_next.st = PUS_OFF;
            s_next.enable = 1'b0;
            s_next.video_on = 1'b0;
            s_next.pending = 1'b0;
        end
        if (s_next.st == PUS_CLK_WAIT && s_reg.st != PUS_CLK_WAIT) begin
            tmr_start = 1'b1;
            tmr_load = TIMER_W'(CLOCK_STABLE_CYCLES);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '{st: PUS_OFF, auto_cfg: AUTO_RESET_CFG_RESET,
                       default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    pus_delay_timer #(
        .W(TIMER_W)
    ) u_timer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .start(tmr_start),
        .load(tmr_load),
        .expired(tmr_expired)
    );

    // a writer still busy after an abort finishes its frame harmlessly
    pus_i2c_writer #(
        .DEV_ADDR(DEV_ADDR),
        .QUARTER(I2C_QUARTER)
    ) u_writer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wr(wr),
        .scl_i(scl_i),
        .scl_o(scl_o),
        .scl_oe(scl_oe),
        .sda_i(sda_i),
        .sda_o(sda_o),
        .sda_oe(sda_oe)
    );

    assign avs_readdata = s_reg.rdata;
    assign power_enable_pin = s_reg.enable;
    assign video_src_enable = s_reg.video_on;
    assign gpio_out = s_reg.gpio_pin;
    assign gpio_oe = s_reg.drive_ok;
endmodule // pus_sequencer
`default_nettype wire

// ===== pus_wr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pus_wr_if;
    logic req;
    logic ready;
    logic [7:0] reg_addr;
    logic [7:0] data;
    logic done;
    logic nack;
    modport seq (output req, output reg_addr, output data,
                 input ready, input done, input nack);
    modport drv (input req, input reg_addr, input data,
                 output ready, output done, output nack);
endinterface
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pus_pkg::*;
    localparam int unsigned RDY = 200;
    localparam int unsigned HLD = 200;
    localparam logic [15:0] EXP_B [8] = '{16'h4010, 16'h4149, 16'h4210,
        16'h4200, 16'h4014, 16'h4149, 16'h4210, 16'h4200};
    logic clk_sys = 1'h0;
    logic rst_n = 1'h0;
    logic [3:0] avs_address = '0;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = '0;
    logic supply_good = 1'h0;
    logic video_clk_stable = 1'h0;
    logic [31:0] avs_readdata;
    logic [3:0] gpio_out;
    logic avs_waitrequest, power_enable_pin, video_src_enable, gpio_oe;
    logic scl_oe, sda_oe, sda_pull;
    wire logic scl = !scl_oe;
    wire logic sda = !(sda_oe || sda_pull);
    int n_errors = 0;
    int n_checks = 0;
    pus_sequencer #(.GPIO_W(4), .READY_CYCLES(RDY), .HOLD_CYCLES(HLD),
        .DEV_ADDR(7'h2a), .I2C_QUARTER(8'h0a)) dut (.clk_sys, .rst_n,
        .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
        .supply_good, .video_clk_stable, .power_enable_pin, .video_src_enable,
        .gpio_out, .gpio_oe, .scl_i(scl), .scl_o(), .scl_oe, .sda_i(sda),
        .sda_o(), .sda_oe);
    pus_dev_model #(.ADDR(7'h2a), .READY(RDY)) dev (.clk_sys,
        .en(power_enable_pin), .scl, .sda, .sda_pull);
    task automatic report_and_stop;
        if (n_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [3:0] a,
        input logic [31:0] d, output logic [31:0] q);
        logic busy;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        busy = 1'h1;
        // look mid-cycle so the value seen is the one the edge will take
        while (busy) begin
            @(negedge clk_sys);
            busy = (avs_waitrequest !== 1'h0);
            q = avs_readdata;
            @(posedge clk_sys);
        end
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        @(posedge clk_sys);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        acc(1'h0, a, '0, q);
        chk(q, e);
    endtask
    // polling keeps the wait on the design's own state, bounded by count
    task automatic wait_st(input logic [8:0] st);
        logic [31:0] q;
        q = '0;
        for (int i = 0; i < 60000 && q[8:0] !== st; i++)
            acc(1'h0, CSR_STATUS, '0, q);
        chk(32'(q[8:0]), 32'(st));
    endtask
    initial begin
        forever #12.5 clk_sys = !clk_sys;
    end
    initial begin
        repeat (90000) @(posedge clk_sys);
        n_errors++;
        report_and_stop;
    end
    initial begin
        logic [31:0] q;
        int n;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'h1;
        @(posedge clk_sys);
        rd_chk(CSR_STATUS, 32'h1);
        rd_chk(CSR_CTRL, 32'h0);
        rd_chk(CSR_AUTO_RESET_CFG, 32'h0);
        acc(1'h1, 4'h2, 32'hff, q);
        rd_chk(4'h2, 32'h0);
        acc(1'h1, CSR_AUTO_RESET_CFG, 32'hff, q);
        acc(1'h1, CSR_GPIO, 32'h5, q);
        acc(1'h1, CSR_CTRL, 32'h1, q);
        repeat (HLD + 20) @(posedge clk_sys);
        rd_chk(CSR_STATUS, 32'h4);
        chk(32'(gpio_out), 32'h0);
        supply_good <= 1'h1;
        wait_st(9'h20);
        chk(32'(dev.log_q.size()), 32'h2);
        chk(32'(dev.log_q[0]), 32'h5bdf);
        chk(32'(dev.log_q[1]), 32'h1602);
        chk(32'(gpio_out), 32'h5);
        repeat (2000) @(posedge clk_sys);
        chk(32'(dev.log_q.size()), 32'h2);
        video_clk_stable <= 1'h1;
        repeat (20) @(posedge clk_sys);
        video_clk_stable <= 1'h0;
        @(posedge clk_sys);
        video_clk_stable <= 1'h1;
        wait_st(9'h80);
        chk(32'(dev.log_q.size()), 32'ha);
        foreach (EXP_B[i]) chk(32'(dev.log_q[i + 2]), 32'(EXP_B[i]));
        chk(32'({dev.auto_rst, dev.pll_hold}), 32'h0);
        supply_good <= 1'h0;
        repeat (3) @(posedge clk_sys);
        chk(32'(power_enable_pin), 32'h0);
        supply_good <= 1'h1;
        wait_st(9'h8);
        acc(1'h1, CSR_CTRL, 32'h2, q);
        n = 0;
        while (power_enable_pin !== 1'h1 && n < 1000) begin
            @(posedge clk_sys);
            n++;
        end
        chk(32'(n + 4 >= HLD), 32'h1);
        acc(1'h1, CSR_CTRL, 32'h4, q);
        wait_st(9'h1);
        chk(32'(power_enable_pin), 32'h0);
        report_and_stop;
    end
endmodule // testbench
bind pus_sequencer pus_chk #(.GPIO_W(GPIO_W), .READY_CYCLES(READY_CYCLES),
    .HOLD_CYCLES(HOLD_CYCLES)) chk (.clk_sys, .rst_n, .supply_good,
    .video_clk_stable, .power_enable_pin, .video_src_enable, .gpio_out,
    .gpio_oe, .scl_oe, .sda_oe);
`default_nettype wire
